// File: rtl/exs_map.vh
`ifndef EXS_MAP_VH
`define EXS_MAP_VH

// Register port offsets, setup reset value and setup bit positions
`define EXS_OFF_SETUP 4'h0
`define EXS_OFF_STATUS 4'h1
`define EXS_SETUP_RESET 8'h0b
`define EXS_BIT_USER_SEL 3
`define EXS_BIT_NMI_EDGE 2

// Flag word mask bits
`define EXS_BIT_PRIMARY 7
`define EXS_BIT_SECONDARY 6

// Vector numbers
`define EXS_VEC_RESET 6'h00
`define EXS_VEC_NMI 6'h07
`define EXS_VEC_TRAP_BASE 6'h08
`define EXS_VEC_EXT0 6'h0c
`define EXS_VEC_EXT1 6'h0d
`define EXS_VEC_INT_FIRST 6'h14
`define EXS_VEC_INT_LAST 6'h3c

// Stack image size in bytes
`define EXS_STACK_STEP 24'h000004

// Reset hold figures for the outside source
`define EXS_HOLD_POWERUP_MS 20
`define EXS_HOLD_RUN_CYCLES 10

`endif

// File: rtl/exs_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser, one per bit
module exs_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire core_clk,
  input wire rstn,
  input wire clk_en,
  input wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);

genvar i;
generate
  for (i = 0; i < W; i = i + 1)
  begin : g_bit
    reg meta_reg;
    reg sync_reg;
    // First stage feeds only the second
    always @(posedge core_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        meta_reg <= INIT[i];
        sync_reg <= INIT[i];
      end
      else if (clk_en)
      begin
        meta_reg <= d_in[i];
        sync_reg <= meta_reg;
      end
    end
    assign q_out[i] = sync_reg;
  end
endgenerate

endmodule

// File: rtl/exs_nmi_edge.v
`timescale 1ns/1ps
// Edge detector for the synchronised nonmask_irq level
module exs_nmi_edge (
  input wire core_clk,
  input wire rstn,
  input wire clk_en,
  input wire nmi_sync,
  input wire rise_sel,
  output wire nmi_event
);

reg last_reg;

// Previous sample of the synchronised level
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
    last_reg <= 1'b1;
  else if (clk_en)
    last_reg <= nmi_sync;
end

// Rising edge when selected, falling edge otherwise
assign nmi_event = clk_en & (rise_sel ? (nmi_sync & ~last_reg)
                                      : (~nmi_sync & last_reg));

endmodule

// File: rtl/exs_sequencer.v
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "exs_map.vh"
module exs_sequencer #(
  parameter AW = 24
) (
  input wire core_clk,
  input wire rstn,
  input wire clk_en,
  input wire hard_init_pin_n,
  input wire nonmask_irq,
  input wire irq_valid,
  input wire [5:0] irq_vec,
  input wire irq_high,
  output wire irq_ack,
  input wire instr_done,
  input wire trap_req,
  input wire [1:0] trap_num,
  output wire trap_ack,
  input wire [AW-1:0] pc_in,
  input wire [7:0] flag_in,
  input wire [AW-1:0] sp_in,
  output reg [AW-1:0] pc_out,
  output reg pc_load,
  output reg [7:0] flag_out,
  output reg flag_load,
  output reg [AW-1:0] sp_out,
  output reg sp_load,
  output wire core_init,
  output wire core_hold,
  output reg [AW-1:0] mem_addr,
  output reg [31:0] mem_wdata,
  output reg mem_rd,
  output reg mem_wr,
  input wire [31:0] mem_rdata,
  input wire mem_ack,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata
);

localparam [2:0] ST_INIT = 3'h0;
localparam [2:0] ST_IDLE = 3'h1;
localparam [2:0] ST_PUSH = 3'h2;
localparam [2:0] ST_VEC = 3'h3;
localparam [2:0] ST_JUMP = 3'h4;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and edge detection

wire [1:0] pins_sync;
wire init_sync_n;
wire nmi_sync;
wire nmi_event;

exs_sync #(
  .W(2),
  .INIT(2'b11) // Both pins idle high, so no false edge after reset
) u_sync (
  .core_clk(core_clk),
  .rstn(rstn),
  .clk_en(clk_en),
  .d_in({hard_init_pin_n, nonmask_irq}),
  .q_out(pins_sync)
);

assign init_sync_n = pins_sync[1];
assign nmi_sync = pins_sync[0];

reg [7:0] setup_reg;

exs_nmi_edge u_edge (
  .core_clk(core_clk),
  .rstn(rstn),
  .clk_en(clk_en),
  .nmi_sync(nmi_sync),
  .rise_sel(setup_reg[`EXS_BIT_NMI_EDGE]),
  .nmi_event(nmi_event)
);

////////////////////////////////////////////////////////////////////////////////
// State

reg [2:0] state_reg;
reg [2:0] state_next;
reg [5:0] vec_reg;
reg is_reset_reg;
reg is_trap_reg;
reg block_reg;
reg nmi_pend_reg;
reg seq_end_reg;

wire user_sel = setup_reg[`EXS_BIT_USER_SEL];
wire idle = (state_reg == ST_IDLE);
wire boundary = instr_done | seq_end_reg;

// Only documented interrupt vectors may be taken
wire vec_legal = (irq_vec == `EXS_VEC_EXT0) || (irq_vec == `EXS_VEC_EXT1) ||
                 ((irq_vec >= `EXS_VEC_INT_FIRST) &&
                  (irq_vec <= `EXS_VEC_INT_LAST));

// Three-level masking from the current flag word
wire prim = flag_in[`EXS_BIT_PRIMARY];
wire sec = flag_in[`EXS_BIT_SECONDARY];
wire mask_ok = ~prim | (~user_sel & ~sec & irq_high);

wire take_nmi = nmi_pend_reg;
wire take_irq = irq_valid & vec_legal & mask_ok;
wire take_int = idle & clk_en & boundary & ~block_reg & (take_nmi | take_irq);
wire take_trap = idle & clk_en & trap_req & ~take_int;

assign irq_ack = take_int & ~take_nmi;
assign trap_ack = take_trap;
assign core_init = ~init_sync_n;
assign core_hold = ~idle | ~init_sync_n;

// Vector to fetch for the accepted source
wire [5:0] vec_pick = take_int ? (take_nmi ? `EXS_VEC_NMI : irq_vec)
                               : (`EXS_VEC_TRAP_BASE | {4'h0, trap_num});

// Push address: stack grows down, even addresses only
wire [AW-1:0] sp_dec = sp_in - `EXS_STACK_STEP;
wire [AW-1:0] push_addr = {sp_dec[AW-1:1], 1'b0};

// Flag word after masking for interrupts and traps
wire [7:0] both_masks = flag_in | (8'h01 << `EXS_BIT_PRIMARY) | (8'h01 << `EXS_BIT_SECONDARY);
wire [7:0] prim_mask = flag_in | (8'h01 << `EXS_BIT_PRIMARY);
wire [7:0] flag_mask = (is_trap_reg & user_sel) ? prim_mask : both_masks;

////////////////////////////////////////////////////////////////////////////////
// Sequencer next state

always @*
begin
  state_next = state_reg;
  case (state_reg)
    ST_INIT:
      if (init_sync_n)
        state_next = ST_VEC;
    ST_IDLE:
      if (take_int || take_trap)
        state_next = ST_PUSH;
    ST_PUSH:
      if (mem_ack)
        state_next = ST_VEC;
    ST_VEC:
      if (mem_ack)
        state_next = ST_JUMP;
    ST_JUMP:
      state_next = ST_IDLE;
    default:
      state_next = ST_INIT;
  endcase
end

// Sequencer registers
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    state_reg <= ST_INIT;
    vec_reg <= `EXS_VEC_RESET;
    is_reset_reg <= 1'b1;
    is_trap_reg <= 1'b0;
    seq_end_reg <= 1'b0;
  end
  else if (!init_sync_n)
  begin
    state_reg <= ST_INIT;
    vec_reg <= `EXS_VEC_RESET;
    is_reset_reg <= 1'b1;
    is_trap_reg <= 1'b0;
    seq_end_reg <= 1'b0;
  end
  else if (clk_en)
  begin
    state_reg <= state_next;
    seq_end_reg <= (state_reg == ST_JUMP) & ~is_reset_reg;
    if (idle && (take_int || take_trap))
    begin
      vec_reg <= vec_pick;
      is_reset_reg <= 1'b0;
      is_trap_reg <= take_trap;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Memory access: longword push, then longword vector fetch; after reset the fetch comes alone

always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    mem_addr <= {AW{1'b0}};
    mem_wdata <= 32'h00000000;
    mem_rd <= 1'b0;
    mem_wr <= 1'b0;
  end
  else if (!init_sync_n)
  begin
    mem_addr <= {AW{1'b0}};
    mem_wdata <= 32'h00000000;
    mem_rd <= 1'b0;
    mem_wr <= 1'b0;
  end
  else if (clk_en)
  begin
    if (state_reg == ST_INIT)
    begin
      mem_addr <= {AW{1'b0}};
      mem_rd <= 1'b1;
    end
    else if (idle && (take_int || take_trap))
    begin
      mem_addr <= push_addr;
      mem_wdata <= {flag_in, pc_in[23:0]};
      mem_wr <= 1'b1;
    end
    else if (state_reg == ST_PUSH && mem_ack)
    begin
      mem_wr <= 1'b0;
      mem_rd <= 1'b1;
      mem_addr <= {{(AW-8){1'b0}}, vec_reg, 2'b00};
    end
    else if (state_reg == ST_VEC && mem_ack)
      mem_rd <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Core register updates

always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    pc_out <= {AW{1'b0}};
    pc_load <= 1'b0;
    flag_out <= 8'h00;
    flag_load <= 1'b0;
    sp_out <= {AW{1'b0}};
    sp_load <= 1'b0;
  end
  else if (!init_sync_n)
  begin
    pc_out <= {AW{1'b0}};
    pc_load <= 1'b0;
    flag_out <= 8'h00;
    flag_load <= 1'b0;
    sp_out <= {AW{1'b0}};
    sp_load <= 1'b0;
  end
  else if (clk_en)
  begin
    pc_load <= 1'b0;
    flag_load <= 1'b0;
    sp_load <= 1'b0;
    if (state_reg == ST_INIT)
    begin
      flag_out <= 8'h01 << `EXS_BIT_PRIMARY;
      flag_load <= 1'b1;
    end
    else if (state_reg == ST_PUSH && mem_ack)
    begin
      sp_out <= push_addr;
      sp_load <= 1'b1;
      flag_out <= flag_mask;
      flag_load <= 1'b1;
    end
    else if (state_reg == ST_VEC && mem_ack)
    begin
      pc_out <= mem_rdata[AW-1:0];
      pc_load <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt gate after reset and nonmask request latch

always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    block_reg <= 1'b1;
    nmi_pend_reg <= 1'b0;
  end
  else if (!init_sync_n)
  begin
    block_reg <= 1'b1;
    nmi_pend_reg <= 1'b0;
  end
  else if (clk_en)
  begin
    // Cleared only when the first program instruction has completed
    if (block_reg && idle && instr_done && !seq_end_reg)
      block_reg <= 1'b0;
    // A new edge wins over the acceptance clear
    if (nmi_event)
      nmi_pend_reg <= 1'b1;
    else if (take_int && take_nmi)
      nmi_pend_reg <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Register port

always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    setup_reg <= `EXS_SETUP_RESET;
    reg_rdata <= 8'h00;
  end
  else if (!init_sync_n)
  begin
    setup_reg <= `EXS_SETUP_RESET;
    reg_rdata <= 8'h00;
  end
  else if (clk_en)
  begin
    if (reg_wr && reg_addr == `EXS_OFF_SETUP)
      setup_reg <= reg_wdata;
    if (reg_rd)
    begin
      case (reg_addr)
        `EXS_OFF_SETUP:
          reg_rdata <= setup_reg;
        `EXS_OFF_STATUS:
          reg_rdata <= {2'b00, block_reg, nmi_pend_reg, is_trap_reg, state_reg};
        default:
          reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end
end

endmodule

// File: verif/exs_props.sv
`timescale 1ns/1ps
// Port-level checks on the exception sequencer
module exs_props #(parameter AW = 24) (
  input wire core_clk,
  input wire rstn,
  input wire hard_init_pin_n,
  input wire irq_ack,
  input wire trap_ack,
  input wire core_init,
  input wire [AW-1:0] pc_in,
  input wire [7:0] flag_in,
  input wire [AW-1:0] sp_in,
  input wire [AW-1:0] pc_out,
  input wire pc_load,
  input wire [7:0] flag_out,
  input wire flag_load,
  input wire [AW-1:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire mem_rd,
  input wire mem_wr,
  input wire [31:0] mem_rdata,
  input wire mem_ack
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_one_ack: assert property (!(irq_ack && trap_ack))
    else $error("two acks at once");
  a_push_addr: assert property ((irq_ack || trap_ack) |=> mem_wr &&
    mem_addr == AW'(($past(sp_in) - 'h4) & ~'h1)) else $error("bad push address");
  a_push_image: assert property ((irq_ack || trap_ack) |=>
    mem_wdata == {$past(flag_in), $past(pc_in)}) else $error("bad stack image");
  a_push_done: assert property (mem_wr && mem_ack |=>
    mem_rd && !mem_wr && flag_load && flag_out[7]) else $error("no fetch after push");
  a_vec_legal: assert property (mem_rd |-> mem_addr[AW-1:8] == 0 &&
    mem_addr[1:0] == 0 && !(mem_addr[7:2] inside {[1:6], [14:19]}))
    else $error("illegal vector");
  a_vec_load: assert property (mem_rd && mem_ack |=> pc_load &&
    {8'h00, pc_out} == ($past(mem_rdata) & 32'h00ffffff)) else $error("bad pc load");
  a_init_quiet: assert property (core_init ##1 core_init |->
    !(irq_ack || trap_ack || mem_rd || mem_wr)) else $error("activity in reset");
  a_reset_fetch: assert property ($rose(hard_init_pin_n) |->
    ##[1:8] mem_rd && mem_addr == 0) else $error("no reset fetch");
  a_reset_nopush: assert property ($rose(hard_init_pin_n) |-> !mem_wr [*8])
    else $error("push during reset");
endmodule

// File: verif/exs_mem_model.sv
`timescale 1ns/1ps
// Memory behind the sequencer: vector table, stack writes
module exs_mem_model (
  input wire core_clk,
  input wire rstn,
  input wire slow,
  input wire mem_rd,
  input wire mem_wr,
  input wire [23:0] mem_addr,
  output reg [31:0] mem_rdata,
  output reg mem_ack
);
  // Ack at once or after random stalls; data toggles when not valid
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if ((mem_rd || mem_wr) && !mem_ack && (!slow || $urandom % 3 == 0))
      begin
        mem_ack <= 1'b1;
        mem_rdata <= {8'h5a, mem_addr + 24'h100};
      end
    end
  end
endmodule

// File: verif/exs_tb.sv
`timescale 1ns/1ps
module testbench;
  logic core_clk, rstn, clk_en, hard_init_pin_n, nonmask_irq, irq_valid, irq_high;
  logic instr_done, trap_req, reg_wr, reg_rd, slow, mem_ack;
  logic [5:0] irq_vec;
  logic [1:0] trap_num;
  logic [23:0] pc_in, sp_in, pc_out, sp_out, mem_addr;
  logic [7:0] flag_in, flag_out, reg_wdata, reg_rdata;
  logic [31:0] mem_wdata, mem_rdata;
  logic [3:0] reg_addr;
  logic irq_ack, trap_ack, pc_load, flag_load, sp_load, core_init, core_hold, mem_rd, mem_wr;
  int n_errors = 0;
  int compares = 0;
  logic [23:0] vq[$];
  logic [23:0] sq[$];
  logic [7:0] fq[$];

  exs_sequencer dut (
    .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .hard_init_pin_n(hard_init_pin_n),
    .nonmask_irq(nonmask_irq), .irq_valid(irq_valid), .irq_vec(irq_vec), .irq_high(irq_high),
    .irq_ack(irq_ack), .instr_done(instr_done), .trap_req(trap_req), .trap_num(trap_num),
    .trap_ack(trap_ack), .pc_in(pc_in), .flag_in(flag_in), .sp_in(sp_in), .pc_out(pc_out),
    .pc_load(pc_load), .flag_out(flag_out), .flag_load(flag_load), .sp_out(sp_out),
    .sp_load(sp_load), .core_init(core_init), .core_hold(core_hold), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );
  exs_mem_model mem (
    .core_clk(core_clk), .rstn(rstn), .slow(slow), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack)
  );

  // 200 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic drain();
    int i;
    for (i = 0; i < 80 && vq.size() > 0; i++)
      @(posedge core_clk);
    chk(vq.size(), 0);
    if (vq.size() > 0)
      conclude();
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, e);
  endtask

  // Present one request set, pulse boundaries for up to 16 cycles until something is taken
  task automatic take(input logic ir, input logic [5:0] v, input logic tr,
                      input logic [1:0] n, input logic [1:0] ft, input logic [1:0] ea,
                      input int ev, input logic [7:0] em);
    int i;
    logic [1:0] seen;
    logic hit;
    logic [7:0] f;
    logic [23:0] sp;
    @(posedge core_clk);
    seen = 2'b00;
    hit = 1'b0;
    f = {ft, 6'($urandom)};
    sp = 24'($urandom);
    if (ev >= 0)
    begin
      vq.push_back(24'(ev));
      fq.push_back(f | em);
      sq.push_back((sp - 24'h4) & 24'hfffffe);
    end
    flag_in <= f;
    sp_in <= sp;
    pc_in <= 24'($urandom);
    slow <= 1'($urandom);
    irq_valid <= ir;
    irq_vec <= v;
    trap_req <= tr;
    trap_num <= n;
    for (i = 0; i < 16 && !hit; i++)
    begin
      instr_done <= !i[0];
      @(negedge core_clk);
      seen = seen | {irq_ack, trap_ack};
      hit = irq_ack | trap_ack | mem_wr;
      @(posedge core_clk);
    end
    irq_valid <= 1'b0;
    trap_req <= 1'b0;
    instr_done <= 1'b0;
    chk(seen, ea);
    if (ev >= 0)
      drain();
  endtask

  // Reference results for every load the sequencer makes
  always @(negedge core_clk)
  begin
    if (sp_load) chk(sp_out, sq.pop_front());
    if (flag_load) chk(flag_out, fq.pop_front());
    if (pc_load) chk(pc_out, 24'h100 + 4 * vq.pop_front());
  end

  ////////////////////////////////////////////////////////////
  initial
  begin
    int k;
    int vi;
    logic hi;
    void'($urandom(61));
    rstn = 1'b0;
    clk_en = 1'b1;
    hard_init_pin_n = 1'b1;
    nonmask_irq = 1'b1;
    {irq_valid, irq_high, instr_done, trap_req, reg_wr, reg_rd, slow} = '0;
    {irq_vec, trap_num, pc_in, sp_in, flag_in, reg_addr, reg_wdata} = '0;
    vq.push_back(24'h0);
    fq.push_back(8'h80);
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    drain();
    irq_valid <= 1'b1;
    irq_vec <= 6'h0c;
    repeat (5)
    begin
      @(negedge core_clk);
      chk(irq_ack | mem_wr, 0);
      chk(core_hold, 0);
    end
    @(posedge core_clk);
    take(1, 12, 0, 0, 2'b00, 2'b10, 12, 8'hc0);
    rd(4'h0, 8'h0b);
    rd(4'hf, 8'h00);
    for (k = 0; k < 4; k++)
    begin
      if (k == 2)
        wr(4'h0, 8'h03);
      take(0, 0, 1, k[1:0], 2'b10, 2'b01, 8 + k, k < 2 ? 8'h80 : 8'hc0);
    end
    rd(4'h0, 8'h03);
    take(1, 13, 1, 2, 2'b00, 2'b10, 13, 8'hc0);
    vi = 20 + $urandom % 41;
    take(1, 6'(vi), 0, 0, 2'b11, 2'b00, -1, 8'h00);
    take(1, 6'(vi), 0, 0, 2'b00, 2'b10, vi, 8'hc0);
    // Request of random level (irq_high) against a primary-only mask
    hi = 1'($urandom);
    irq_high <= hi;
    take(1, 6'(vi), 0, 0, 2'b10, hi ? 2'b10 : 2'b00, hi ? vi : -1, 8'hc0);
    // Nonmask pulse, falling edge first, then rising edge
    for (k = 0; k < 2; k++)
    begin
      if (k == 1)
        wr(4'h0, 8'h07);
      @(posedge core_clk);
      nonmask_irq <= 1'b0;
      repeat (3) @(posedge core_clk);
      nonmask_irq <= 1'b1;
      take(0, 0, 0, 0, 2'b11, 2'b00, 7, 8'hc0);
    end
    @(posedge core_clk);
    hard_init_pin_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    chk(core_init, 1);
    chk(core_hold, 1);
    vq.push_back(24'h0);
    fq.push_back(8'h80);
    hard_init_pin_n <= 1'b1;
    drain();
    rd(4'h1, 8'h21);
    rd(4'h0, 8'h0b);
    conclude();
  end
endmodule

bind exs_sequencer exs_props #(.AW(AW)) u_props (
  .core_clk(core_clk), .rstn(rstn), .hard_init_pin_n(hard_init_pin_n), .irq_ack(irq_ack),
  .trap_ack(trap_ack), .core_init(core_init), .pc_in(pc_in), .flag_in(flag_in), .sp_in(sp_in),
  .pc_out(pc_out), .pc_load(pc_load), .flag_out(flag_out), .flag_load(flag_load),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .mem_rdata(mem_rdata), .mem_ack(mem_ack)
);
